// [hdl/tdx_fault_keeper.sv]
`timescale 1ns/1ps
module tdx_fault_keeper
    import tdx_pkg::*;
(
    // clock and reset
    input  wire logic  clk_in,
    input  wire logic  nrst_in,
    input  wire logic  ce_in,
    // flag traffic from the register bank
    tdx_flag_if.keeper fl
);
    typedef struct packed {
        logic [31:0] flags;
        logic [31:0] enable;
    } tdx_keep_type;

    tdx_keep_type st;
    tdx_keep_type next_st;

    // sticky flags, set beats clear in the same cycle
    always_comb
    begin
        next_st = st;
        next_st.flags = ((st.flags & ~fl.clear) | fl.cause) & ERR_MASK;
        if (fl.en_we)
        begin
            next_st.enable = fl.en_wdata & ERR_MASK;
        end
        if (fl.soft_rst)
        begin
            next_st.flags  = ERR_RST;
            next_st.enable = IRQ_EN_RST;
        end
    end

    // state register
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            st.flags  <= ERR_RST;
            st.enable <= IRQ_EN_RST;
        end
        else if (ce_in)
        begin
            st <= next_st;
        end
    end

    // level interrupt toward the host
    assign fl.flags  = st.flags;
    assign fl.enable = st.enable;
    assign fl.irq    = |(st.flags & st.enable);
endmodule

// [hdl/tdx_flag_if.sv]
`timescale 1ns/1ps
interface tdx_flag_if;
    logic [31:0] cause;
    logic [31:0] clear;
    logic        soft_rst;
    logic        en_we;
    logic [31:0] en_wdata;
    logic [31:0] flags;
    logic [31:0] enable;
    logic        irq;

    modport producer (output cause, clear, soft_rst, en_we, en_wdata,
                      input flags, enable, irq);
    modport keeper   (input cause, clear, soft_rst, en_we, en_wdata,
                      output flags, enable, irq);
endinterface

// [hdl/tdx_pkg.sv]
package tdx_pkg;
    // register byte offsets on the avalon slave
    localparam logic [4:0] ADDR_COUNTS  = 5'h00;
    localparam logic [4:0] ADDR_EXEC    = 5'h04;
    localparam logic [4:0] ADDR_ORDER   = 5'h08;
    localparam logic [4:0] ADDR_ERRF    = 5'h0C;
    localparam logic [4:0] ADDR_IRQ_EN  = 5'h10;
    localparam logic [4:0] ADDR_IRQ_CLR = 5'h14;
    localparam logic [4:0] ADDR_STATUS  = 5'h18;
    // field positions
    localparam int unsigned CNT_HI_LSB    = 16;
    localparam int unsigned ORDER_SOFT    = 1;
    localparam int unsigned ORDER_HALF    = 0;
    localparam int unsigned ERR_ITER      = 14;
    localparam int unsigned ERR_MEM       = 11;
    localparam int unsigned ERR_OUTP      = 10;
    localparam int unsigned ERR_TABLE     = 9;
    localparam int unsigned ERR_SNR       = 8;
    localparam int unsigned ERR_REL       = 7;
    localparam int unsigned ERR_SF        = 4;
    localparam int unsigned ERR_P         = 2;
    localparam int unsigned ERR_F         = 1;
    localparam int unsigned ERR_SUM       = 0;
    localparam int unsigned STAT_HALTED   = 3;
    localparam int unsigned STAT_BIG      = 4;
    // writable / readable masks, reserved bits stay zero
    localparam logic [31:0] ERR_MASK      = 32'h00004F97;
    localparam logic [31:0] ORDER_MASK    = 32'h00000003;
    // reset values and counter saturation value
    localparam logic [31:0] COUNTS_RST    = 32'h00000000;
    localparam logic [1:0]  ORDER_RST     = 2'h0;
    localparam logic [31:0] ERR_RST       = 32'h00000000;
    localparam logic [31:0] IRQ_EN_RST    = 32'h00000000;
    localparam logic [15:0] CNT_MAX       = 16'hFFFF;
    // map states in which debug stepping waits
    localparam logic [2:0]  MAP_HALT_INIT = 3'h0;
    localparam logic [2:0]  MAP_HALT_STEP = 3'h6;

    typedef enum logic [2:0] {
        CMD_NOP      = 3'b000,
        CMD_START    = 3'b001,
        CMD_UNDEF2   = 3'b010,
        CMD_UNDEF3   = 3'b011,
        CMD_INIT     = 3'b100,
        CMD_STEP     = 3'b101,
        CMD_REST     = 3'b110,
        CMD_SOFT_RST = 3'b111
    } tdx_cmd_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RUN   = 3'b001,
        ST_HALT0 = 3'b010,
        ST_STEP  = 3'b011,
        ST_HALT6 = 3'b100
    } tdx_state_type;
endpackage

// [hdl/tdx_regs.sv]
`timescale 1ns/1ps
// How it works
// - Upper counter half holds re-encode errors of the interleaved second decoder.
// - Lower counter half holds re-encode errors of the first decoder.
// - Command field: code zero does nothing, code one starts a normal decode.
// - Code four initialises, then halts waiting in map state zero.
// - Code five runs one map decode, then halts waiting in map state six.
// - Code six runs the remaining decodes and ends normally, leaving stepping.
// - Code seven resets everything except the command and byte order registers.
// - Reserved bits read zero and writes to them change nothing.
// - Byte order bit one picks the extrinsic table byte view.
// - Byte order bit zero picks interleaver halfword view; ignored in little-endian.
// - Any detected error records its cause and the summary flag; it raises the host interrupt if its own or the summary enable bit is set.
// - Read-only error word resets to zero, with iteration, cause and summary flags.
// - Memory access outside a debug halt sets the memory timing flag.
// - In shared mode a set output parameter read flag sets its flag.
// - In shared mode an interleaver table load request sets its flag.
module tdx_regs
    import tdx_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        ce_in,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // decoder core events
    input  wire logic        reenc_first_in,
    input  wire logic        reenc_second_in,
    input  wire logic        map_done_in,
    input  wire logic        decode_done_in,
    input  wire logic        mem_access_in,
    input  wire logic        sp_mode_in,
    input  wire logic        outparam_flag_in,
    input  wire logic        table_load_req_in,
    input  wire logic        iter_bound_in,
    input  wire logic [4:0]  other_fault_in,
    // endian strap pin
    input  wire logic        big_endian_in,
    // table data through the byte order views
    input  wire logic [63:0] soft_info_in,
    input  wire logic [63:0] permute_in,
    output logic      [63:0] soft_info_out,
    output logic      [63:0] permute_out,
    // decoder core control
    output logic             start_out,
    output logic             init_out,
    output logic             step_out,
    output logic             rest_out,
    output logic             soft_reset_out,
    output logic             halted_out,
    output logic      [2:0]  halt_map_state_out,
    output logic             busy_out,
    // interrupt
    output logic             irq_out
);
    typedef struct packed {
        logic          ack;
        logic [31:0]   rdata;
        logic [15:0]   cnt_second;
        logic [15:0]   cnt_first;
        tdx_cmd_type   cmd;
        logic [1:0]    order;
        tdx_state_type fsm;
        logic          start;
        logic          init;
        logic          step;
        logic          rest;
        logic          srst;
        logic          big_meta;
        logic          big_sync;
        logic [63:0]   soft_info;
        logic [63:0]   permute;
    } tdx_regs_type;

    tdx_regs_type st;
    tdx_regs_type next_st;

    tdx_flag_if fl ();

    logic        req;
    logic        acc_wr;
    logic        first;
    logic [31:0] bmask;
    logic        halted;
    logic [31:0] cause;
    tdx_cmd_type wcmd;

    // flag keeper holds error word, enables and interrupt
    tdx_fault_keeper u_keeper (
        .clk_in  (clk_in),
        .nrst_in (nrst_in),
        .ce_in   (ce_in),
        .fl      (fl)
    );

    // bus handshake, one wait state per access
    assign req    = avs_read_in | avs_write_in;
    assign first  = req & ~st.ack;
    assign acc_wr = avs_write_in & st.ack;
    assign avs_waitrequest_out = req & ~(st.ack & ce_in); // no answer while frozen
    assign wcmd   = tdx_cmd_type'(avs_writedata_in[2:0]);
    assign halted = (st.fsm == ST_HALT0) || (st.fsm == ST_HALT6);

    // byte enables widened to a bit mask
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            bmask[i*8 +: 8] = {8{avs_byteenable_in[i]}};
        end
    end

    // cause vector of this cycle
    always_comb
    begin
        cause = 32'h00000000;
        cause[ERR_ITER]  = iter_bound_in;
        cause[ERR_MEM]   = mem_access_in & ~halted;
        cause[ERR_OUTP]  = sp_mode_in & outparam_flag_in;
        cause[ERR_TABLE] = sp_mode_in & table_load_req_in;
        cause[ERR_SNR]   = other_fault_in[4];
        cause[ERR_REL]   = other_fault_in[3];
        cause[ERR_SF]    = other_fault_in[2];
        cause[ERR_P]     = other_fault_in[1];
        cause[ERR_F]     = other_fault_in[0];
        cause[ERR_SUM]   = |cause[31:1];
    end

    // flag keeper traffic
    assign fl.cause    = cause;
    assign fl.clear    = (acc_wr && avs_address_in == ADDR_IRQ_CLR) ?
                         (avs_writedata_in & bmask) : 32'h00000000;
    assign fl.soft_rst = acc_wr && avs_address_in == ADDR_EXEC &&
                         avs_byteenable_in[0] && wcmd == CMD_SOFT_RST;
    assign fl.en_we    = acc_wr && avs_address_in == ADDR_IRQ_EN;
    assign fl.en_wdata = (avs_writedata_in & bmask) | (fl.enable & ~bmask);

    // next state
    always_comb
    begin
        next_st = st;
        next_st.ack   = first;
        next_st.start = 1'b0;
        next_st.init  = 1'b0;
        next_st.step  = 1'b0;
        next_st.rest  = 1'b0;
        next_st.srst  = 1'b0;
        next_st.big_meta = big_endian_in;
        next_st.big_sync = st.big_meta;

        // read data latched in the wait cycle, reserved bits zero
        if (avs_read_in && first)
        begin
            unique case (avs_address_in)
                ADDR_COUNTS:  next_st.rdata = {st.cnt_second, st.cnt_first};
                ADDR_ORDER:   next_st.rdata = {30'h0, st.order};
                ADDR_ERRF:    next_st.rdata = fl.flags;
                ADDR_IRQ_EN:  next_st.rdata = fl.enable;
                ADDR_STATUS:  next_st.rdata = {27'h0, st.big_sync, halted, st.fsm};
                default:      next_st.rdata = 32'h00000000;
            endcase
        end

        // re-encode counters, saturating
        if (reenc_second_in && st.cnt_second != CNT_MAX)
        begin
            next_st.cnt_second = st.cnt_second + 16'h0001;
        end
        if (reenc_first_in && st.cnt_first != CNT_MAX)
        begin
            next_st.cnt_first = st.cnt_first + 16'h0001;
        end
        if (acc_wr && avs_address_in == ADDR_COUNTS)
        begin
            next_st.cnt_second = (avs_writedata_in[31:16] & bmask[31:16]) |
                                 (st.cnt_second & ~bmask[31:16]);
            next_st.cnt_first  = (avs_writedata_in[15:0] & bmask[15:0]) |
                                 (st.cnt_first & ~bmask[15:0]);
        end

        // byte order register, only two bits kept
        if (acc_wr && avs_address_in == ADDR_ORDER && avs_byteenable_in[0])
        begin
            next_st.order = avs_writedata_in[1:0] & ORDER_MASK[1:0];
        end

        // decoder sequencing
        unique case (st.fsm)
            ST_RUN:
            begin
                if (decode_done_in)
                begin
                    next_st.fsm = ST_IDLE;
                end
            end
            ST_STEP:
            begin
                if (map_done_in)
                begin
                    next_st.fsm = ST_HALT6;
                end
            end
            ST_IDLE, ST_HALT0, ST_HALT6:
            begin
            end
            default:
            begin
                next_st.fsm = ST_IDLE;
            end
        endcase

        // command register writes
        if (acc_wr && avs_address_in == ADDR_EXEC && avs_byteenable_in[0])
        begin
            next_st.cmd = wcmd;
            unique case (wcmd)
                CMD_START:
                begin
                    if (st.fsm == ST_IDLE)
                    begin
                        next_st.fsm   = ST_RUN;
                        next_st.start = 1'b1;
                    end
                end
                CMD_INIT:
                begin
                    if (st.fsm == ST_IDLE)
                    begin
                        next_st.fsm  = ST_HALT0;
                        next_st.init = 1'b1;
                    end
                end
                CMD_STEP:
                begin
                    if (halted)
                    begin
                        next_st.fsm  = ST_STEP;
                        next_st.step = 1'b1;
                    end
                end
                CMD_REST:
                begin
                    if (halted)
                    begin
                        next_st.fsm  = ST_RUN;
                        next_st.rest = 1'b1;
                    end
                end
                CMD_SOFT_RST:
                begin
                    next_st.fsm        = ST_IDLE;
                    next_st.srst       = 1'b1;
                    next_st.cnt_second = 16'h0000;
                    next_st.cnt_first  = 16'h0000;
                    next_st.soft_info  = 64'h0000000000000000;
                    next_st.permute    = 64'h0000000000000000;
                end
                CMD_NOP, CMD_UNDEF2, CMD_UNDEF3:
                begin
                    // no instruction, decoder state untouched
                    next_st.fsm = st.fsm;
                end
            endcase
        end

        // extrinsic table byte view
        for (int b = 0; b < 8; b++)
        begin
            if (st.order[ORDER_SOFT])
            begin
                next_st.soft_info[(7-b)*8 +: 8] = soft_info_in[b*8 +: 8];
            end
            else
            begin
                next_st.soft_info[b*8 +: 8] = soft_info_in[(b ^ 3)*8 +: 8];
            end
        end

        // interleaver halfword view, big-endian only
        for (int h = 0; h < 4; h++)
        begin
            if (st.order[ORDER_HALF] && st.big_sync)
            begin
                next_st.permute[(3-h)*16 +: 16] = permute_in[h*16 +: 16];
            end
            else
            begin
                next_st.permute[h*16 +: 16] = permute_in[(h ^ 1)*16 +: 16];
            end
        end
    end

    // state register
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            st            <= '0;
            st.cnt_second <= COUNTS_RST[31:16];
            st.cnt_first  <= COUNTS_RST[15:0];
            st.order      <= ORDER_RST;
            st.cmd        <= CMD_NOP;
            st.fsm        <= ST_IDLE;
        end
        else if (ce_in)
        begin
            st <= next_st;
        end
    end

    // outputs
    assign avs_readdata_out   = st.rdata;
    assign soft_info_out      = st.soft_info;
    assign permute_out        = st.permute;
    assign start_out          = st.start;
    assign init_out           = st.init;
    assign step_out           = st.step;
    assign rest_out           = st.rest;
    assign soft_reset_out     = st.srst;
    assign halted_out         = halted;
    assign halt_map_state_out = (st.fsm == ST_HALT6) ? MAP_HALT_STEP : MAP_HALT_INIT;
    assign busy_out           = (st.fsm == ST_RUN) || (st.fsm == ST_STEP);
    assign irq_out            = fl.irq;
endmodule

// [tb/tdx_core_model.sv]
`timescale 1ns/1ps
module tdx_core_model #(
    parameter int DLY = 4
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic nrst_in,
    // control pulses from the register bank
    input  wire logic start_in,
    input  wire logic step_in,
    input  wire logic rest_in,
    // completion pulses back to it
    output logic      map_done_out,
    output logic      decode_done_out
);
    int m;
    int d;

    // each launch pulse answers with one done pulse, dly cycles later
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            m <= 0;
            d <= 0;
            map_done_out <= 1'b0;
            decode_done_out <= 1'b0;
        end
        else
        begin
            m <= step_in ? DLY : (m != 0 ? m - 1 : 0);
            d <= (start_in || rest_in) ? DLY : (d != 0 ? d - 1 : 0);
            map_done_out <= (m == 1);
            decode_done_out <= (d == 1);
        end
    end
endmodule

// [tb/tdx_regs_checker.sv]
`timescale 1ns/1ps
module tdx_regs_checker
    import tdx_pkg::*;
(
    // clock and reset
    input wire logic        clk_in,
    input wire logic        nrst_in,
    input wire logic        ce_in,
    // avalon side
    input wire logic [4:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    // core side
    input wire logic        map_done_in,
    input wire logic        decode_done_in,
    input wire logic        big_endian_in,
    input wire logic [63:0] permute_in,
    input wire logic [63:0] permute_out,
    input wire logic        start_out,
    input wire logic        init_out,
    input wire logic        step_out,
    input wire logic        rest_out,
    input wire logic        soft_reset_out,
    input wire logic        halted_out,
    input wire logic [2:0]  halt_map_state_out,
    input wire logic        busy_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    // completed write of one command code
    sequence s_exec(logic [2:0] code);
        avs_write_in && !avs_waitrequest_out && avs_address_in == ADDR_EXEC
            && avs_writedata_in[2:0] == code;
    endsequence

    sequence s_rd_done(logic [4:0] a);
        avs_read_in && !avs_waitrequest_out && avs_address_in == a;
    endsequence

    a_one_wait_state: assert property (ce_in && (avs_read_in || avs_write_in)
        && avs_waitrequest_out |=> !avs_waitrequest_out) else $error("wait state count");
    a_start_run: assert property (s_exec(1) ##0 !busy_out && !halted_out
        |=> start_out && busy_out) else $error("start not taken");
    a_init_halt: assert property (s_exec(4) ##0 !busy_out && !halted_out |=> init_out
        && halted_out && halt_map_state_out == MAP_HALT_INIT) else $error("init halt");
    a_step_launch: assert property (s_exec(5) ##0 halted_out
        |=> step_out && busy_out && !halted_out) else $error("step not taken");
    a_rest_launch: assert property (s_exec(6) ##0 halted_out
        |=> rest_out && busy_out) else $error("rest not taken");
    a_undef_noop: assert property ((s_exec(0) or s_exec(2) or s_exec(3)) ##0 !map_done_in
        && !decode_done_in |=> $stable(busy_out) && $stable(halted_out) && !start_out
        && !init_out) else $error("undefined code acted");
    a_soft_reset: assert property (s_exec(7) |=> soft_reset_out && !busy_out
        && !halted_out ##1 !soft_reset_out) else $error("soft reset");
    a_exec_read_zero: assert property (s_rd_done(ADDR_EXEC)
        |-> avs_readdata_out == 32'h00000000) else $error("command reads back");
    a_err_reserved: assert property (s_rd_done(ADDR_ERRF)
        |-> (avs_readdata_out & ~ERR_MASK) == 32'h00000000) else $error("reserved set");
    a_little_view: assert property ((!big_endian_in)[*5] |-> permute_out == {$past(permute_in[47:32]),
        $past(permute_in[63:48]), $past(permute_in[15:0]), $past(permute_in[31:16])})
        else $error("little halfword view");
endmodule

bind tdx_regs tdx_regs_checker i_chk (.*);

// [tb/test_tdx_regs.sv]
`timescale 1ns/1ps
module test_tdx_regs
    import tdx_pkg::*;
;
    logic        clk_in, nrst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
    logic [4:0]  avs_address_in, other_fault_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, q;
    logic        reenc_first_in, reenc_second_in, map_done_in, decode_done_in, mem_access_in;
    logic        sp_mode_in, outparam_flag_in, table_load_req_in, iter_bound_in, big_endian_in;
    logic [63:0] soft_info_in, permute_in, soft_info_out, permute_out;
    logic        start_out, init_out, step_out, rest_out, soft_reset_out;
    logic        halted_out, busy_out, irq_out;
    logic [2:0]  halt_map_state_out;
    int          n_mismatch, check_count;

    tdx_regs i_dut (.ce_in(1'b1), .avs_byteenable_in(4'hF), .*);

    tdx_core_model #(.DLY(4)) i_core (.clk_in(clk_in), .nrst_in(nrst_in), .start_in(start_out),
        .step_in(step_out), .rest_in(rest_out), .map_done_out(map_done_in),
        .decode_done_out(decode_done_in));

    // 200 mhz clock
    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic end_of_test();
        if (n_mismatch == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= !w;
        @(posedge clk_in);
        while (avs_waitrequest_out !== 1'b0 && n < 100)
        begin
            @(posedge clk_in);
            n++;
        end
        if (n == 100)
        begin
            n_mismatch++;
            end_of_test();
        end
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(nm, {32'h00000000, e}, {32'h00000000, q});
    endtask

    // bounded wait for a core state: halted level and busy level
    task automatic wait_st(input logic h, input logic b);
        int n;
        n = 0;
        while ((halted_out !== h || busy_out !== b) && n < 50)
        begin
            @(posedge clk_in);
            n++;
        end
        if (n == 50)
        begin
            n_mismatch++;
            end_of_test();
        end
    endtask

    // all error sources for one cycle
    task automatic fault(input logic it, input logic [4:0] of, input logic sp, input logic ma);
        iter_bound_in <= it;
        other_fault_in <= of;
        sp_mode_in <= sp;
        outparam_flag_in <= 1'b1;
        table_load_req_in <= 1'b1;
        mem_access_in <= ma;
        @(posedge clk_in);
        {iter_bound_in, sp_mode_in, outparam_flag_in, table_load_req_in, mem_access_in} <= 5'h00;
        other_fault_in <= 5'h00;
        @(posedge clk_in);
        @(posedge clk_in);
    endtask

    initial
    begin
        {nrst_in, avs_read_in, avs_write_in, reenc_first_in, reenc_second_in} = 5'h00;
        {mem_access_in, sp_mode_in, outparam_flag_in, table_load_req_in} = 4'h0;
        {iter_bound_in, big_endian_in} = 2'h0;
        {avs_address_in, other_fault_in, avs_writedata_in} = 42'h0;
        soft_info_in = 64'h0706050403020100;
        permute_in = 64'h0003000200010000;
        n_mismatch = 0;
        check_count = 0;
        repeat (12) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        // reset values
        rd("counts", ADDR_COUNTS, 32'h00000000);
        rd("command", ADDR_EXEC, 32'h00000000);
        rd("order", ADDR_ORDER, 32'h00000000);
        rd("errors", ADDR_ERRF, 32'h00000000);
        // counters per decoder, then plain write
        {reenc_first_in, reenc_second_in} <= 2'h3;
        repeat (2) @(posedge clk_in);
        reenc_second_in <= 1'b0;
        @(posedge clk_in);
        reenc_first_in <= 1'b0;
        @(posedge clk_in);
        rd("counts", ADDR_COUNTS, 32'h00020003);
        bus(1'b1, ADDR_COUNTS, 32'h12345678);
        rd("counts", ADDR_COUNTS, 32'h12345678);
        // byte order views, big-endian host only
        bus(1'b1, ADDR_ORDER, 32'hFFFFFFFF);
        rd("order", ADDR_ORDER, 32'h00000003);
        big_endian_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk("soft view", 64'h0001020304050607, soft_info_out);
        chk("half view", 64'h0000000100020003, permute_out);
        bus(1'b1, ADDR_ORDER, 32'h00000000);
        repeat (4) @(posedge clk_in);
        chk("soft view", 64'h0405060700010203, soft_info_out);
        chk("half view", 64'h0002000300000001, permute_out);
        big_endian_in <= 1'b0;
        // debug stepping
        bus(1'b1, ADDR_EXEC, 32'h00000004);
        chk("halt0", 64'h8, {halted_out, halt_map_state_out});
        rd("status", ADDR_STATUS, 32'h0000000A);
        fault(1'b0, 5'h00, 1'b0, 1'b1);
        bus(1'b1, ADDR_EXEC, 32'h00000002);
        bus(1'b1, ADDR_EXEC, 32'h00000003);
        chk("undef", 64'h1, {busy_out, halted_out});
        bus(1'b1, ADDR_EXEC, 32'hFFFFFFF5);
        wait_st(1'b1, 1'b0);
        chk("halt6", 64'h6, halt_map_state_out);
        bus(1'b1, ADDR_EXEC, 32'h00000006);
        wait_st(1'b0, 1'b0);
        rd("errors", ADDR_ERRF, 32'h00000000);
        bus(1'b1, ADDR_EXEC, 32'h00000001);
        chk("busy", 64'h1, busy_out);
        wait_st(1'b0, 1'b0);
        // error word and interrupt
        bus(1'b1, ADDR_IRQ_EN, 32'hFFFFFFFF);
        rd("enable", ADDR_IRQ_EN, 32'h00004F97);
        fault(1'b1, 5'h1F, 1'b1, 1'b1);
        chk("irq", 64'h1, irq_out);
        rd("errors", ADDR_ERRF, 32'h00004F97);
        bus(1'b1, ADDR_IRQ_CLR, 32'hFFFFFFFF);
        rd("errors", ADDR_ERRF, 32'h00000000);
        chk("irq", 64'h0, irq_out);
        bus(1'b1, ADDR_IRQ_EN, 32'h00004000);
        fault(1'b0, 5'h01, 1'b0, 1'b0);
        chk("irq", 64'h0, irq_out);
        rd("errors", ADDR_ERRF, 32'h00000003);
        fault(1'b1, 5'h00, 1'b0, 1'b0);
        chk("irq", 64'h1, irq_out);
        // soft reset keeps byte order only
        bus(1'b1, ADDR_ORDER, 32'h00000003);
        bus(1'b1, ADDR_COUNTS, 32'h00050006);
        bus(1'b1, ADDR_EXEC, 32'h00000007);
        rd("counts", ADDR_COUNTS, 32'h00000000);
        rd("errors", ADDR_ERRF, 32'h00000000);
        rd("enable", ADDR_IRQ_EN, 32'h00000000);
        rd("order", ADDR_ORDER, 32'h00000003);
        chk("irq", 64'h0, irq_out);
        // unmapped place
        bus(1'b1, 5'h1C, 32'hFFFFFFFF);
        rd("unmapped", 5'h1C, 32'h00000000);
        end_of_test();
    end
endmodule
